/* common/cp0_cfg_consts.vh */
// Constants for the translation config and counter register bank.
// Assumes inclusion by the register bank modules, their checker and their bench.
`ifndef CP0_CFG_CONSTS_VH
`define CP0_CFG_CONSTS_VH
// ************************************************************
// Register numbers (register, select) packed as {reg[4:0],sel[2:0]}
// ************************************************************
`define REGSEL_THREAD_LOCAL 8'h22
`define REGSEL_PAGE_MASK    8'h28
`define REGSEL_WIRED        8'h30
`define REGSEL_SHADOW_CONF  8'h31
`define REGSEL_HW_MASK      8'h38
`define REGSEL_FAULT_VADDR  8'h40
`define REGSEL_COUNT        8'h48
// ************************************************************
// Field layouts and values
// ************************************************************
`define PAGE_MASK_LSB       13
`define PAGE_MASK_MSB       28
`define WIRED_MSB           5
`define HW_MASK_MSB         29
`define SHADOW_UNSUPPORTED  10'h3FF
`define SHADOW_UNASSIGNED   10'h3FE
`define HWREG_CPU_NUMBER    5'h00
`define HWREG_SYNC_STEP     5'h01
`define HWREG_CYCLE_COUNT   5'h02
`define HWREG_COUNT_RES     5'h03
`define HWREG_USER_LOCAL    5'h1D
`define CACHE_SYNC_STEP     32'h00000020
`define COUNT_RESOLUTION    32'h00000002
`define HW_MASK_IMPL        30'h2000000F
`define EXC_LOAD_ADDR       5'h04
`define EXC_STORE_ADDR      5'h05
`define EXC_TLB_MOD         5'h01
`define EXC_TLB_LOAD        5'h02
`define EXC_TLB_STORE       5'h03
`endif

/* rtl/count_divider.v */
// Two-cycle enable divider for the interval counter.
// Assumes a single core clock and active-low asynchronous reset.
`timescale 1ns/10ps
module count_divider (
   // Clock and reset
   input  wire       clock_i,
   input  wire       rst_n_i,
   // Control
   input  wire       run_i,
   // Enable out
   output reg        tick_o
);
   // ************************************************************
   // Divider
   // ************************************************************
   reg               phase_q;

   // Phase keeps toggling so pausing does not bias the rate
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         phase_q <= 1'b0;
         tick_o  <= 1'b0;
      end else begin
         phase_q <= ~phase_q;
         tick_o  <= run_i & phase_q;
      end
   end
endmodule // count_divider

/* rtl/hwreg_read_unit.v */
// Read-hardware-register decode and value select.
// Assumes the sources are stable in the cycle of the request.
`timescale 1ns/10ps
`include "cp0_cfg_consts.vh"
module hwreg_read_unit (
   // Clock and reset
   input  wire        clock_i,
   input  wire        rst_n_i,
   // Request
   input  wire        req_i,
   input  wire [4:0]  num_i,
   input  wire        cp0_enabled_i,
   input  wire [29:0] access_mask_i,
   // Sources
   input  wire [9:0]  cpu_number_i,
   input  wire [31:0] count_i,
   input  wire [31:0] user_local_i,
   // Answer
   output reg         done_o,
   output reg         fault_o,
   output reg  [31:0] data_o
);
   // ************************************************************
   // Decode
   // ************************************************************
   reg                impl;
   reg                allowed;
   reg  [31:0]        value;

   always @* begin
      impl  = 1'b1;
      value = 32'h00000000;
      case (num_i)
         `HWREG_CPU_NUMBER:  value = {22'h000000, cpu_number_i};
         `HWREG_SYNC_STEP:   value = `CACHE_SYNC_STEP;
         `HWREG_CYCLE_COUNT: value = count_i;
         `HWREG_COUNT_RES:   value = `COUNT_RESOLUTION;
         `HWREG_USER_LOCAL:  value = user_local_i;
         default:            impl  = 1'b0;
      endcase
      // Reserved numbers fault even with coprocessor 0 enabled
      allowed = impl & (cp0_enabled_i |
                (num_i <= 5'h1D && access_mask_i[num_i]));
   end

   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         done_o  <= 1'b0;
         fault_o <= 1'b0;
         data_o  <= 32'h00000000;
      end else begin
         done_o  <= req_i;
         fault_o <= req_i & ~allowed;
         if (req_i && allowed) begin
            data_o <= value;
         end
      end
   end
endmodule // hwreg_read_unit

/* rtl/tlb_cfg_hwreg_counter_regs.v */
// System-control register bank: page mask, wired boundary, shadow
// set binding, hardware-register mask, faulting address, counter.
// Assumes the core presents move-to/from requests one cycle each.
// ************************************************************
// Overview of operation
// - Page mask holds nine pairwise encodings
// - All-ones write reads back implemented sizes
// - Random writes skip entries below wired
// - Wired boundary cleared by reset
// - Wired write sets random index top
// - Wired in bits 5:0, rest zero
// - Binding write updates highest shadow set
// - Binding fields show unsupported or unassigned
// - Bits 31 and 30 read zero
// - User hardware read needs mask bit
// - Numbers 0,2 give cpu, counter
// - Number 1 gives sync step 32
// - Number 3 gives resolution 2
// - Reserved numbers raise reserved instruction
// - Mask reads back only implemented bits
// - Fault address captures address exceptions only
// - Counter increments every other clock
// - Counter writable; debug bit gates counting
// ************************************************************
`timescale 1ns/10ps
`include "cp0_cfg_consts.vh"
module tlb_cfg_hwreg_counter_regs #(
   parameter TLB_ENTRIES   = 32,
   parameter SHADOW_SETS   = 3,
   parameter PAGE_SIZES    = 9
) (
   // Clock and reset
   input  wire        clock_i,
   input  wire        rst_n_i,
   // Coprocessor move port
   input  wire        mtc0_i,
   input  wire        mfc0_i,
   input  wire [7:0]  regsel_i,
   input  wire [31:0] wdata_i,
   // Core state
   input  wire        count_disable_bit_i,
   input  wire        count_in_debug_bit_i,
   input  wire        debug_mode_i,
   input  wire        cp0_enabled_i,
   input  wire [9:0]  cpu_number_i,
   input  wire [3:0]  current_shadow_set_i,
   input  wire [3:0]  previous_shadow_set_i,
   // Exception capture
   input  wire        exc_i,
   input  wire [4:0]  exc_code_i,
   input  wire [31:0] exc_vaddr_i,
   // Translation writes
   input  wire        tlb_write_random_instr_i,
   input  wire        tlb_write_indexed_instr_i,
   input  wire [5:0]  index_i,
   // Hardware register read
   input  wire        hwr_req_i,
   input  wire [4:0]  hwr_num_i,
   // Register read answer
   output reg         rdata_valid_o,
   output reg  [31:0] rdata_o,
   // Translation write target and highest shadow set
   output reg         tlb_we_o,
   output reg  [5:0]  tlb_widx_o,
   output reg  [5:0]  random_index_o,
   output reg  [3:0]  highest_shadow_set_o,
   // Hardware register answer
   output wire        hwr_done_o,
   output wire        hwr_fault_o,
   output wire [31:0] hwr_data_o
);
   // ************************************************************
   // Constants
   // ************************************************************
   localparam integer TOP_WIDE  = TLB_ENTRIES - 1;
   localparam integer SETS_WIDE = SHADOW_SETS;
   localparam [5:0] TOP_INDEX = TOP_WIDE[5:0];
   localparam [2:0] SETS      = SETS_WIDE[2:0];
   // Implemented page sizes as a pair mask over bits 28:13
   localparam [15:0] PAGE_IMPL = (PAGE_SIZES >= 9) ? 16'hFFFF :
                                 ((16'h0001 << (2*(PAGE_SIZES-1))) -
                                  16'h0001);

   // ************************************************************
   // State
   // ************************************************************
   reg  [15:0]        page_mask_q;
   reg  [5:0]         wired_q;
   reg  [5:0]         random_q;
   reg  [29:0]        shadow_conf_q;
   reg  [29:0]        hw_mask_q;
   reg  [31:0]        fault_vaddr_q;
   reg  [31:0]        count_q;
   reg  [31:0]        thread_local_q;
   reg                rst_sync_done_q;
   wire               tick;
   wire               count_run;

   // ************************************************************
   // Helpers
   // ************************************************************
   function wr_hit;
      input [7:0] sel;
      begin
         wr_hit = mtc0_i && (regsel_i == sel);
      end
   endfunction

   // Keep only whole implemented pairs, each pair bit set together
   function [15:0] legal_mask;
      input [15:0] m;
      integer k;
      begin
         legal_mask = 16'h0000;
         for (k = 0; k < 8; k = k + 1) begin
            if (m[2*k] & m[2*k+1]) begin
               legal_mask[2*k]   = 1'b1;
               legal_mask[2*k+1] = 1'b1;
            end
         end
         legal_mask = legal_mask & PAGE_IMPL;
      end
   endfunction

   // A binding field is unsupported above the built sets
   function [9:0] bind_field;
      input [9:0] v;
      input [2:0] n;
      begin
         if (n > SETS) begin
            bind_field = `SHADOW_UNSUPPORTED;
         end else begin
            bind_field = (v == `SHADOW_UNSUPPORTED) ?
                         `SHADOW_UNASSIGNED : v;
         end
      end
   endfunction

   // Highest set whose field is a real binding
   function [3:0] highest_valid;
      input [29:0] c;
      begin
         if (c[29:20] < `SHADOW_UNASSIGNED) begin
            highest_valid = 4'h3;
         end else if (c[19:10] < `SHADOW_UNASSIGNED) begin
            highest_valid = 4'h2;
         end else if (c[9:0] < `SHADOW_UNASSIGNED) begin
            highest_valid = 4'h1;
         end else begin
            highest_valid = 4'h0;
         end
      end
   endfunction

   // ************************************************************
   // Page mask, wired boundary and random index
   // ************************************************************
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         page_mask_q    <= 16'h0000;
         wired_q        <= 6'h00;
         random_q       <= 6'h00;
         random_index_o <= 6'h00;
         tlb_we_o       <= 1'b0;
         tlb_widx_o     <= 6'h00;
      end else begin
         if (wr_hit(`REGSEL_PAGE_MASK)) begin
            page_mask_q <= legal_mask(wdata_i[28:13]);
         end
         // Random index walks down and wraps at the wired boundary
         if (wr_hit(`REGSEL_WIRED)) begin
            wired_q  <= wdata_i[5:0];
            random_q <= TOP_INDEX;
         end else if (random_q <= wired_q) begin
            random_q <= TOP_INDEX;
         end else begin
            random_q <= random_q - 6'h01;
         end
         random_index_o <= random_q;
         tlb_we_o <= tlb_write_random_instr_i | tlb_write_indexed_instr_i;
         if (tlb_write_indexed_instr_i) begin
            tlb_widx_o <= index_i;
         end else if (tlb_write_random_instr_i) begin
            tlb_widx_o <= (random_q < wired_q) ? TOP_INDEX : random_q;
         end
      end
   end

   // ************************************************************
   // Shadow set binding
   // ************************************************************
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         shadow_conf_q        <= {`SHADOW_UNSUPPORTED, `SHADOW_UNSUPPORTED,
                                  `SHADOW_UNSUPPORTED};
         highest_shadow_set_o <= 4'h0;
      end else if (wr_hit(`REGSEL_SHADOW_CONF)) begin
         shadow_conf_q <= {bind_field(wdata_i[29:20], 3'h3),
                           bind_field(wdata_i[19:10], 3'h2),
                           bind_field(wdata_i[9:0], 3'h1)};
         // Software must keep this at or above current set
         highest_shadow_set_o <= highest_valid({
            bind_field(wdata_i[29:20], 3'h3),
            bind_field(wdata_i[19:10], 3'h2),
            bind_field(wdata_i[9:0], 3'h1)});
      end else if (!rst_sync_done_q) begin
         shadow_conf_q <= {bind_field(10'h3FE, 3'h3),
                           bind_field(10'h3FE, 3'h2),
                           bind_field(10'h3FE, 3'h1)};
      end
   end

   // Seed the built sets as unassigned once after release
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_sync_done_q <= 1'b0;
      end else begin
         rst_sync_done_q <= 1'b1;
      end
   end

   // ************************************************************
   // Access mask, thread local word, faulting address
   // ************************************************************
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         hw_mask_q      <= 30'h00000000;
         thread_local_q <= 32'h00000000;
         fault_vaddr_q  <= 32'h00000000;
      end else begin
         if (wr_hit(`REGSEL_HW_MASK)) begin
            hw_mask_q <= wdata_i[29:0] & `HW_MASK_IMPL;
         end
         if (wr_hit(`REGSEL_THREAD_LOCAL)) begin
            thread_local_q <= wdata_i;
         end
         // Cache and bus errors carry other codes and are ignored
         if (exc_i && (exc_code_i == `EXC_LOAD_ADDR ||
                       exc_code_i == `EXC_STORE_ADDR ||
                       exc_code_i == `EXC_TLB_MOD ||
                       exc_code_i == `EXC_TLB_LOAD ||
                       exc_code_i == `EXC_TLB_STORE)) begin
            fault_vaddr_q <= exc_vaddr_i;
         end
      end
   end

   // ************************************************************
   // Interval counter
   // ************************************************************
   assign count_run = ~count_disable_bit_i &
                      (~debug_mode_i | count_in_debug_bit_i);

   count_divider u_div (
      .clock_i (clock_i),
      .rst_n_i (rst_n_i),
      .run_i   (count_run),
      .tick_o  (tick)
   );

   // Software write wins over a tick in the same cycle
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         count_q <= 32'h00000000;
      end else if (wr_hit(`REGSEL_COUNT)) begin
         count_q <= wdata_i;
      end else if (tick && count_run) begin
         count_q <= count_q + 32'h00000001;
      end
   end

   // ************************************************************
   // Register read
   // ************************************************************
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_valid_o <= 1'b0;
         rdata_o       <= 32'h00000000;
      end else begin
         rdata_valid_o <= mfc0_i;
         if (mfc0_i) begin
            case (regsel_i)
               `REGSEL_PAGE_MASK:
                  rdata_o <= {3'h0, page_mask_q, 13'h0000};
               `REGSEL_WIRED:
                  rdata_o <= {26'h0000000, wired_q};
               `REGSEL_SHADOW_CONF:
                  rdata_o <= {2'h0, shadow_conf_q};
               `REGSEL_HW_MASK:
                  rdata_o <= {2'h0, hw_mask_q};
               `REGSEL_FAULT_VADDR:
                  rdata_o <= fault_vaddr_q;
               `REGSEL_COUNT:
                  rdata_o <= count_q;
               `REGSEL_THREAD_LOCAL:
                  rdata_o <= thread_local_q;
               default:
                  rdata_o <= 32'h00000000;
            endcase
         end
      end
   end

   // ************************************************************
   // Hardware register read unit
   // ************************************************************
   hwreg_read_unit u_hwr (
      .clock_i       (clock_i),
      .rst_n_i       (rst_n_i),
      .req_i         (hwr_req_i),
      .num_i         (hwr_num_i),
      .cp0_enabled_i (cp0_enabled_i),
      .access_mask_i (hw_mask_q),
      .cpu_number_i  (cpu_number_i),
      .count_i       (count_q),
      .user_local_i  (thread_local_q),
      .done_o        (hwr_done_o),
      .fault_o       (hwr_fault_o),
      .data_o        (hwr_data_o)
   );

   // Shadow set inputs are advisory for software only
   wire unused_sets = ^{current_shadow_set_i, previous_shadow_set_i};
endmodule // tlb_cfg_hwreg_counter_regs

/* verification/tlb_cfg_hwreg_counter_regs_asserts.sv */
// Port checker for the register bank.
// Assumes binding by the statement below this module.
`timescale 1ns/10ps
`include "cp0_cfg_consts.vh"
module tlb_cfg_hwreg_counter_regs_asserts #(
   parameter TLB_ENTRIES = 32,
   parameter SHADOW_SETS = 3,
   parameter PAGE_SIZES  = 9
) (
   // Clock and reset
   input wire        clock_i,
   input wire        rst_n_i,
   // Requests
   input wire        mtc0_i,
   input wire        mfc0_i,
   input wire [7:0]  regsel_i,
   input wire [31:0] wdata_i,
   input wire        cp0_enabled_i,
   input wire        tlb_write_random_instr_i,
   input wire        tlb_write_indexed_instr_i,
   input wire [5:0]  index_i,
   input wire        hwr_req_i,
   input wire [4:0]  hwr_num_i,
   // Answers
   input wire [31:0] rdata_o,
   input wire        rdata_valid_o,
   input wire        tlb_we_o,
   input wire [5:0]  tlb_widx_o,
   input wire [5:0]  random_index_o,
   input wire        hwr_done_o,
   input wire        hwr_fault_o
);
   // ********
   // Helpers
   // ********
   localparam int TOP = TLB_ENTRIES - 1;
   reg  [5:0] wired_q;
   wire       resv = hwr_num_i > 5'h03 && hwr_num_i != `HWREG_USER_LOCAL;
   // Shadow of the boundary, so random targets are judged
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i)
         wired_q <= 6'h00;
      else if (mtc0_i && regsel_i == `REGSEL_WIRED)
         wired_q <= wdata_i[5:0];
   end
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   sequence hw_fault_s; hwr_done_o && hwr_fault_o; endsequence
   sequence hw_ok_s; hwr_done_o && !hwr_fault_o; endsequence
   // ********
   // Properties
   // ********
   wired_read_a: assert property (mfc0_i && regsel_i == `REGSEL_WIRED
      |=> rdata_valid_o && rdata_o == {26'h0, wired_q})
      else $error("wired read wrong");
   wired_random_a: assert property (mtc0_i && regsel_i == `REGSEL_WIRED
      |-> ##[1:2] random_index_o == TOP) else $error("random not at top");
   random_skip_a: assert property (tlb_write_random_instr_i
      |=> tlb_we_o && tlb_widx_o >= wired_q && tlb_widx_o <= TOP)
      else $error("random write hit wired entry");
   indexed_a: assert property (tlb_write_indexed_instr_i
      |=> tlb_we_o && tlb_widx_o == $past(index_i))
      else $error("indexed write target wrong");
   binding_top_a: assert property (mfc0_i && regsel_i == `REGSEL_SHADOW_CONF
      |=> rdata_o[31:30] == 2'b00) else $error("binding top bits set");
   page_zero_a: assert property (mfc0_i && regsel_i == `REGSEL_PAGE_MASK
      |=> rdata_o[31:29] == 3'h0 && rdata_o[12:0] == 13'h0)
      else $error("page mask reserved bits set");
   mask_impl_a: assert property (mfc0_i && regsel_i == `REGSEL_HW_MASK
      |=> (rdata_o & ~{2'b00, `HW_MASK_IMPL}) == 32'h0)
      else $error("mask shows unbuilt bit");
   reserved_num_a: assert property (hwr_req_i && resv |=> hw_fault_s)
      else $error("reserved number not refused");
   user_gate_a: assert property (hwr_req_i && !resv && cp0_enabled_i
      |=> hw_ok_s) else $error("privileged read refused");
endmodule // tlb_cfg_hwreg_counter_regs_asserts

bind tlb_cfg_hwreg_counter_regs tlb_cfg_hwreg_counter_regs_asserts #(
   .TLB_ENTRIES(TLB_ENTRIES), .SHADOW_SETS(SHADOW_SETS),
   .PAGE_SIZES(PAGE_SIZES)
) asserts_inst (
   .clock_i(clock_i), .rst_n_i(rst_n_i), .mtc0_i(mtc0_i),
   .mfc0_i(mfc0_i), .regsel_i(regsel_i), .wdata_i(wdata_i),
   .cp0_enabled_i(cp0_enabled_i),
   .tlb_write_random_instr_i(tlb_write_random_instr_i),
   .tlb_write_indexed_instr_i(tlb_write_indexed_instr_i),
   .index_i(index_i), .hwr_req_i(hwr_req_i), .hwr_num_i(hwr_num_i),
   .rdata_o(rdata_o), .rdata_valid_o(rdata_valid_o), .tlb_we_o(tlb_we_o),
   .tlb_widx_o(tlb_widx_o), .random_index_o(random_index_o),
   .hwr_done_o(hwr_done_o), .hwr_fault_o(hwr_fault_o)
);

/* verification/tlb_cfg_hwreg_counter_regs_test.sv */
// Self-checking bench for the register bank.
// Assumes the checker file is compiled alongside.
`timescale 1ns/10ps
`include "cp0_cfg_consts.vh"
module tlb_cfg_hwreg_counter_regs_test;
   // ********
   // Signals
   // ********
   localparam TE = 16;
   reg         clock_i, rst_n_i, mtc0_i, mfc0_i, exc_i, hwr_req_i;
   reg         cdis_i, cdbg_i, dbg_i, cp0_i, rnd_i, idx_i;
   reg  [7:0]  regsel_i;
   reg  [31:0] wdata_i, vaddr_i;
   reg  [9:0]  cpu_i;
   reg  [3:0]  css_i, pss_i;
   reg  [4:0]  code_i, num_i;
   reg  [5:0]  index_i;
   wire        valid_o, we_o, done_o, fault_o;
   wire [31:0] rdata_o, hdata_o;
   wire [5:0]  widx_o, random_o;
   wire [3:0]  hss_o;
   integer     failures, checks_done, cyc, tcap, i, n, m, s;
   reg  [31:0] lfsr_q, rd, a, x, fv;
   reg  [5:0]  w;
   reg         f;

   tlb_cfg_hwreg_counter_regs #(.TLB_ENTRIES(TE), .SHADOW_SETS(2),
      .PAGE_SIZES(9)) tlb_cfg_hwreg_counter_regs_inst (
      .clock_i(clock_i), .rst_n_i(rst_n_i), .mtc0_i(mtc0_i),
      .mfc0_i(mfc0_i), .regsel_i(regsel_i), .wdata_i(wdata_i),
      .count_disable_bit_i(cdis_i), .count_in_debug_bit_i(cdbg_i),
      .debug_mode_i(dbg_i), .cp0_enabled_i(cp0_i), .cpu_number_i(cpu_i),
      .current_shadow_set_i(css_i), .previous_shadow_set_i(pss_i),
      .exc_i(exc_i), .exc_code_i(code_i), .exc_vaddr_i(vaddr_i),
      .tlb_write_random_instr_i(rnd_i), .tlb_write_indexed_instr_i(idx_i),
      .index_i(index_i), .hwr_req_i(hwr_req_i), .hwr_num_i(num_i),
      .rdata_valid_o(valid_o), .rdata_o(rdata_o), .tlb_we_o(we_o),
      .tlb_widx_o(widx_o), .random_index_o(random_o),
      .highest_shadow_set_o(hss_o), .hwr_done_o(done_o),
      .hwr_fault_o(fault_o), .hwr_data_o(hdata_o));

   initial begin
      clock_i = 1'b0;
      forever #12.5 clock_i = ~clock_i;
   end
   always @(posedge clock_i) cyc <= cyc + 1;
   // ********
   // Tasks
   // ********
   function [31:0] lfsr(input [31:0] v);
      lfsr = {v[30:0], 1'b0} ^ (v[31] ? 32'h000000C5 : 32'h00000000);
   endfunction
   task chk(input [31:0] got, input [31:0] exp);
      begin
         checks_done = checks_done + 1;
         if (got !== exp) begin
            failures = failures + 1;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   task close_out;
      begin
         $display("checks %0d failures %0d", checks_done, failures);
         if (failures == 0 && checks_done > 0)
            $display("All tests passed");
         else
            $display("Some tests failed");
         $finish;
      end
   endtask
   // Bounded poll; a lost answer ends the run
   task wait_ans(input hw);
      integer k;
      begin
         k = 0;
         #1;
         while ((hw ? done_o : valid_o) !== 1'b1) begin
            k = k + 1;
            if (k > 4) begin
               failures = failures + 1;
               close_out;
            end
            @(posedge clock_i);
            #1;
         end
      end
   endtask
   task wr(input [7:0] sel, input [31:0] d);
      begin
         @(posedge clock_i);
         mtc0_i <= 1'b1;
         regsel_i <= sel;
         wdata_i <= d;
         @(posedge clock_i);
         mtc0_i <= 1'b0;
      end
   endtask
   task rdreg(input [7:0] sel, output [31:0] d);
      begin
         @(posedge clock_i);
         mfc0_i <= 1'b1;
         regsel_i <= sel;
         @(posedge clock_i);
         mfc0_i <= 1'b0;
         tcap = cyc;
         wait_ans(1'b0);
         d = rdata_o;
      end
   endtask
   task hw(input [4:0] k, output flt, output [31:0] d);
      begin
         @(posedge clock_i);
         hwr_req_i <= 1'b1;
         num_i <= k;
         @(posedge clock_i);
         hwr_req_i <= 1'b0;
         wait_ans(1'b1);
         flt = fault_o;
         d = hdata_o;
      end
   endtask
   task tlbw(input r, input [5:0] k);
      begin
         @(posedge clock_i);
         rnd_i <= r;
         idx_i <= !r;
         index_i <= k;
         @(posedge clock_i);
         rnd_i <= 1'b0;
         idx_i <= 1'b0;
         #1;
      end
   endtask
   // Two reads a known span apart; halves the span when running
   task span_chk(input run);
      integer t0;
      begin
         rdreg(`REGSEL_COUNT, a);
         t0 = tcap;
         repeat (9) @(posedge clock_i);
         rdreg(`REGSEL_COUNT, rd);
         s = tcap - t0;
         if (run)
            chk(2 * (rd - a) + 1 >= s && 2 * (rd - a) <= s + 1, 1);
         else
            chk(rd, a);
      end
   endtask
   // ********
   // Sequence
   // ********
   initial begin
      {rst_n_i, mtc0_i, mfc0_i, exc_i, hwr_req_i, rnd_i, idx_i} = 7'h00;
      {cdis_i, cdbg_i, dbg_i, cp0_i} = 4'h0;
      {regsel_i, wdata_i, vaddr_i, code_i, num_i, index_i} = 88'h0;
      lfsr_q = 32'h030d;
      cpu_i = lfsr_q[9:0];
      {css_i, pss_i} = 8'h00;
      failures = 0;
      checks_done = 0;
      cyc = 0;
      repeat (6) @(posedge clock_i);
      rst_n_i <= 1'b1;
      repeat (2) @(posedge clock_i);
      rdreg(`REGSEL_WIRED, rd); chk(rd, 0);
      rdreg(`REGSEL_HW_MASK, rd); chk(rd, 0);
      rdreg(8'h07, rd); chk(rd, 0);
      rdreg(`REGSEL_SHADOW_CONF, rd); chk(rd, 32'h3FFFFBFE);
      chk(hss_o, 0);
      // Unsupported set 3 stays 0x3FF whatever is written
      wr(`REGSEL_SHADOW_CONF, {2'b11, 10'h155, 10'h3FF, 10'h005});
      rdreg(`REGSEL_SHADOW_CONF, rd); chk(rd, 32'h3FFFF805);
      chk(hss_o, 1);
      wr(`REGSEL_SHADOW_CONF, {2'b00, 10'h3FE, 10'h00A, 10'h003});
      rdreg(`REGSEL_SHADOW_CONF, rd); chk(rd, 32'h3FF02803);
      chk(hss_o, 2);
      for (i = 0; i < 9; i = i + 1) begin
         x = ((32'h1 << (2 * i)) - 1) << 13;
         wr(`REGSEL_PAGE_MASK, x | 32'hE0001FFF);
         rdreg(`REGSEL_PAGE_MASK, rd); chk(rd, x);
      end
      wr(`REGSEL_PAGE_MASK, 32'hFFFFFFFF);
      rdreg(`REGSEL_PAGE_MASK, rd); chk(rd, 32'h1FFFE000);
      lfsr_q = lfsr(lfsr_q);
      x = lfsr_q;
      wr(`REGSEL_THREAD_LOCAL, x);
      for (m = 0; m < 3; m = m + 1) begin
         wr(`REGSEL_HW_MASK, m == 0 ? 32'hFFFFFFFF : 32'h0);
         if (m == 0) begin
            rdreg(`REGSEL_HW_MASK, rd); chk(rd, 32'h2000000F);
         end
         @(posedge clock_i);
         cp0_i <= (m == 2);
         for (n = 0; n < 32; n = n + 1) begin
            hw(n, f, rd);
            chk(f, !(n < 4 || n == 29) || m == 1);
            if (!f && n != 2)
               chk(rd, n == 0 ? {22'h0, cpu_i} : n == 1 ? 32'h20 :
                  n == 3 ? 32'h2 : x);
         end
      end
      @(posedge clock_i);
      cdis_i <= 1'b1;
      lfsr_q = lfsr(lfsr_q);
      wr(`REGSEL_COUNT, lfsr_q);
      rdreg(`REGSEL_COUNT, rd); chk(rd, lfsr_q);
      hw(5'h02, f, rd); chk(rd, lfsr_q);
      span_chk(1'b0);
      @(posedge clock_i);
      cdis_i <= 1'b0;
      span_chk(1'b1);
      @(posedge clock_i);
      dbg_i <= 1'b1;
      span_chk(1'b0);
      @(posedge clock_i);
      cdbg_i <= 1'b1;
      span_chk(1'b1);
      // Codes 6, 7 and 0 stand for non-address faults
      for (i = 1; i < 9; i = i + 1) begin
         lfsr_q = lfsr(lfsr_q);
         @(posedge clock_i);
         exc_i <= 1'b1;
         code_i <= i % 8;
         vaddr_i <= lfsr_q;
         @(posedge clock_i);
         exc_i <= 1'b0;
         if (i < 6)
            fv = lfsr_q;
         rdreg(`REGSEL_FAULT_VADDR, rd); chk(rd, fv);
      end
      wr(`REGSEL_FAULT_VADDR, ~fv);
      rdreg(`REGSEL_FAULT_VADDR, rd); chk(rd, fv);
      w = lfsr_q[5:0] % TE;
      wr(`REGSEL_WIRED, w);
      rdreg(`REGSEL_WIRED, rd); chk(rd, w);
      for (i = 0; i < 6; i = i + 1) begin
         tlbw(i != 5, 6'h00);
         chk(we_o, 1);
         chk(i == 5 ? widx_o == 0 : widx_o >= w && widx_o < TE, 1);
      end
      close_out;
   end
   initial begin
      #2000000;
      failures = failures + 1;
      close_out;
   end
endmodule // tlb_cfg_hwreg_counter_regs_test
